// >>> rtl/hpp_channel.sv
// one host port channel: input, output and status registers
`timescale 1ns/1ns
`default_nettype none
module hpp_channel #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic portOn,
    input wire logic hostWrDone,
    input wire logic hostRdDone,
    input wire logic cmdDataLevel,
    input wire logic [WIDTH-1:0] hostData,
    input wire logic slvInRead,
    input wire logic slvOutWrite,
    input wire logic slvStsWrite,
    input wire logic [WIDTH-1:0] slvData,
    output logic [WIDTH-1:0] inData,
    output logic [WIDTH-1:0] outData,
    output logic [WIDTH-1:0] status
);
    // ****************************************
    // input data register
    // ****************************************
    // host-write only; no reset, contents undefined after reset
    always_ff @(posedge mclk) begin
        if (clkEn && portOn && hostWrDone) begin
            inData <= hostData;
        end
    end

    // ****************************************
    // output data register
    // ****************************************
    // slave-write only; host only reads it
    always_ff @(posedge mclk) begin
        if (clkEn && portOn && slvOutWrite) begin
            outData <= slvData;
        end
    end

    // ****************************************
    // status register
    // ****************************************
    // hardware sets win over clears arriving in the same cycle
    always_ff @(posedge mclk) begin
        if (!nrst || (clkEn && !portOn)) begin
            status <= hpp_pkg::RST_STATUS[WIDTH-1:0];
        end else if (clkEn) begin
            if (slvStsWrite) begin
                status <= (status & ~hpp_pkg::STS_USER_MASK[WIDTH-1:0])
                    | (slvData & hpp_pkg::STS_USER_MASK[WIDTH-1:0]);
            end
            if (hostWrDone) begin
                status[hpp_pkg::STS_CMD_DATA] <= cmdDataLevel;
                status[hpp_pkg::STS_INPUT_FULL] <= 1'b1;
            end else if (slvInRead) begin
                status[hpp_pkg::STS_INPUT_FULL] <= 1'b0;
            end
            if (slvOutWrite) begin
                status[hpp_pkg::STS_OUTPUT_FULL] <= 1'b1;
            end else if (hostRdDone) begin
                status[hpp_pkg::STS_OUTPUT_FULL] <= 1'b0;
            end
        end
    end
endmodule // hpp_channel
`default_nettype wire

// >>> rtl/hpp_host_port.sv
// top of the dual-channel host parallel port with slave register access
`timescale 1ns/1ns
`default_nettype none
// How it works
// - port idle unless enable bit set, except the fast gate while control bit zero stays set
// - gated register window needs enable bit
// - each select reaches only its channel
// - address line picks output or status
// - host write strobe rise captures data
// - write latches address line as command flag
// - input register host-write, slave-read only
// - output drives bus on select, read, line low
// - output register slave-writable, host-read only
// - flag bits read-only, user bits slave-writable
// - status clears on reset and standby
// - control resets F8, top bits fixed ones
// - bit two gates channel two interrupt
// - bit one gates channel one interrupt
// - bit zero enables hardware gate output
// - system control resets 09, bit three fixed
// - input full: host write sets, slave read clears
// - output full: slave write sets, host read clears
// - command flag one means command byte
// - gate follows data bit after command D1 on channel one
module hpp_host_port #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic standby,
    input wire logic chan1SelectN,
    input wire logic chan2SelectN,
    input wire logic cmdDataAddrLine,
    input wire logic hostReadStrobeN,
    input wire logic hostWriteStrobeN,
    input wire logic [7:0] hostDataBusIn,
    output logic [7:0] hostDataBusOut,
    output logic hostDataBusOeN,
    input wire logic cpuRd,
    input wire logic cpuWr,
    input wire logic [15:0] cpuAddr,
    input wire logic [7:0] cpuWdata,
    output logic [7:0] cpuRdata,
    output logic cpuAck,
    output logic ch1InfullIrq,
    output logic ch2InfullIrq,
    output logic addressLineGateOut,
    output logic portEnabled
);
    // ****************************************
    // host pin synchronisers
    // ****************************************
    hpp_pkg::hpp_host_pins_t pinsRaw;
    hpp_pkg::hpp_host_pins_t pinsMeta_q;
    hpp_pkg::hpp_host_pins_t pins_q;
    hpp_pkg::hpp_host_pins_t pinsPrev_q;
    hpp_pkg::hpp_cpu_req_t req;

    assign pinsRaw = '{chan1SelectN, chan2SelectN, cmdDataAddrLine,
        hostReadStrobeN, hostWriteStrobeN, hostDataBusIn};
    assign req = '{cpuRd, cpuWr, cpuAddr, cpuWdata};

    // two flops before any logic looks at host pins; strobes idle high at reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pinsMeta_q <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
            pins_q <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
            pinsPrev_q <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
        end else if (clkEn) begin
            pinsMeta_q <= pinsRaw;
            pins_q <= pinsMeta_q;
            pinsPrev_q <= pins_q;
        end
    end

    // ****************************************
    // slave-side system registers
    // ****************************************
    logic [7:0] sysCtl_q;
    logic [7:0] serialTimerCtl_q;
    logic [7:0] portCtl_q;
    logic portOn;
    logic inGated;

    assign portOn = sysCtl_q[hpp_pkg::SYS_PORT_ENABLE_BIT];
    assign inGated = (req.addr >= hpp_pkg::ADDR_GATED_LO)
        && (req.addr <= hpp_pkg::ADDR_GATED_HI);

    // system control; bit three kept at its reset value
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sysCtl_q <= hpp_pkg::RST_SYSTEM_CONTROL;
        end else if (clkEn && req.wr && req.addr == hpp_pkg::ADDR_SYSTEM_CONTROL) begin
            sysCtl_q <= (req.wdata & ~hpp_pkg::SYS_READ_ONLY_MASK)
                | (sysCtl_q & hpp_pkg::SYS_READ_ONLY_MASK);
        end
    end

    // serial/timer control is held only as plain storage here
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serialTimerCtl_q <= hpp_pkg::RST_SERIAL_TIMER_CONTROL;
        end else if (clkEn && req.wr && req.addr == hpp_pkg::ADDR_SERIAL_TIMER_CONTROL) begin
            serialTimerCtl_q <= req.wdata;
        end
    end

    // port control; upper bits are forced ones, standby reloads it
    always_ff @(posedge mclk) begin
        if (!nrst || (clkEn && standby)) begin
            portCtl_q <= hpp_pkg::RST_HOST_PORT_CONTROL;
        end else if (clkEn && portOn && req.wr
            && req.addr == hpp_pkg::ADDR_HOST_PORT_CONTROL) begin
            portCtl_q <= req.wdata | hpp_pkg::CTL_FIXED_ONES;
        end
    end

    // ****************************************
    // host strobe decode
    // ****************************************
    logic wrRise;
    logic rdRise;
    logic [1:0] selHit;
    logic [1:0] hostWrDone;
    logic [1:0] hostRdDone;
    logic bothStrobes;

    // rising edges of the sampled strobes finish a host access
    assign wrRise = pins_q.hostWriteStrobeN && !pinsPrev_q.hostWriteStrobeN;
    assign rdRise = pins_q.hostReadStrobeN && !pinsPrev_q.hostReadStrobeN;
    // select is judged from the cycle before the rise, still inside the strobe
    assign selHit = {!pinsPrev_q.chan2SelectN, !pinsPrev_q.chan1SelectN};
    // both strobes low is undefined; the device simply ignores it
    assign bothStrobes = !pinsPrev_q.hostReadStrobeN && !pinsPrev_q.hostWriteStrobeN;

    // ****************************************
    // channels
    // ****************************************
    logic [1:0] slvInRead;
    logic [1:0] slvOutWrite;
    logic [1:0] slvStsWrite;
    logic [7:0] inData [2];
    logic [7:0] outData [2];
    logic [7:0] status [2];
    logic chanActive;

    // standby and a disabled port both hold the channels inactive
    assign chanActive = portOn && !standby;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : gChan
            localparam logic [15:0] IN_ADDR = (ch == 0) ? hpp_pkg::ADDR_HOST_IN_DATA_CH1
                : hpp_pkg::ADDR_HOST_IN_DATA_CH2;
            localparam logic [15:0] OUT_ADDR = (ch == 0) ? hpp_pkg::ADDR_HOST_OUT_DATA_CH1
                : hpp_pkg::ADDR_HOST_OUT_DATA_CH2;
            localparam logic [15:0] STS_ADDR = (ch == 0) ? hpp_pkg::ADDR_HOST_STATUS_CH1
                : hpp_pkg::ADDR_HOST_STATUS_CH2;
            // same logic for both channels, only select and addresses differ
            assign hostWrDone[ch] = wrRise && selHit[ch] && !bothStrobes;
            assign hostRdDone[ch] = rdRise && selHit[ch] && !bothStrobes
                && !pinsPrev_q.cmdDataAddrLine;
            assign slvInRead[ch] = req.rd && req.addr == IN_ADDR && portOn;
            assign slvOutWrite[ch] = req.wr && req.addr == OUT_ADDR && portOn;
            assign slvStsWrite[ch] = req.wr && req.addr == STS_ADDR && portOn;

            hpp_channel #(
                .WIDTH(WIDTH)
            ) uChan (
                .mclk(mclk),
                .nrst(nrst),
                .clkEn(clkEn),
                .portOn(chanActive),
                .hostWrDone(hostWrDone[ch]),
                .hostRdDone(hostRdDone[ch]),
                .cmdDataLevel(pinsPrev_q.cmdDataAddrLine),
                .hostData(pinsPrev_q.hostDataBus),
                .slvInRead(slvInRead[ch]),
                .slvOutWrite(slvOutWrite[ch]),
                .slvStsWrite(slvStsWrite[ch]),
                .slvData(req.wdata),
                .inData(inData[ch]),
                .outData(outData[ch]),
                .status(status[ch])
            );
        end
    endgenerate

    // ****************************************
    // slave read port
    // ****************************************
    logic [7:0] rdMux;

    // gated window reads zero while the port is disabled
    always_comb begin
        rdMux = 8'h00;
        case (req.addr)
            hpp_pkg::ADDR_SYSTEM_CONTROL: rdMux = sysCtl_q;
            hpp_pkg::ADDR_SERIAL_TIMER_CONTROL: rdMux = serialTimerCtl_q;
            hpp_pkg::ADDR_HOST_PORT_CONTROL: rdMux = portCtl_q;
            hpp_pkg::ADDR_HOST_IN_DATA_CH1: rdMux = inData[0];
            hpp_pkg::ADDR_HOST_OUT_DATA_CH1: rdMux = outData[0];
            hpp_pkg::ADDR_HOST_STATUS_CH1: rdMux = status[0];
            hpp_pkg::ADDR_HOST_IN_DATA_CH2: rdMux = inData[1];
            hpp_pkg::ADDR_HOST_OUT_DATA_CH2: rdMux = outData[1];
            hpp_pkg::ADDR_HOST_STATUS_CH2: rdMux = status[1];
            default: rdMux = 8'h00;
        endcase
        if (inGated && !portOn) begin
            rdMux = 8'h00;
        end
    end

    // read data and ack registered one cycle after the request
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cpuRdata <= 8'h00;
            cpuAck <= 1'b0;
        end else if (clkEn) begin
            cpuAck <= req.rd || req.wr;
            if (req.rd) begin
                cpuRdata <= rdMux;
            end
        end
    end

    // ****************************************
    // host read bus drive
    // ****************************************
    // enable is registered from the twice-sampled pins, so it lags the host by three cycles
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hostDataBusOut <= 8'h00;
            hostDataBusOeN <= 1'b1;
        end else if (clkEn) begin
            hostDataBusOeN <= 1'b1;
            hostDataBusOut <= 8'h00;
            if (chanActive && !pins_q.hostReadStrobeN && pins_q.hostWriteStrobeN) begin
                if (!pins_q.chan1SelectN && pins_q.chan2SelectN) begin
                    hostDataBusOeN <= 1'b0;
                    hostDataBusOut <= pins_q.cmdDataAddrLine ? status[0]
                        : outData[0];
                end else if (!pins_q.chan2SelectN && pins_q.chan1SelectN) begin
                    hostDataBusOeN <= 1'b0;
                    hostDataBusOut <= pins_q.cmdDataAddrLine ? status[1]
                        : outData[1];
                end
            end
        end
    end

    // ****************************************
    // interrupts and fast gate
    // ****************************************
    logic gateArmed_q;

    // input-full flags gated by their enables
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ch1InfullIrq <= 1'b0;
            ch2InfullIrq <= 1'b0;
            portEnabled <= 1'b0;
        end else if (clkEn) begin
            ch1InfullIrq <= status[0][hpp_pkg::STS_INPUT_FULL]
                && portCtl_q[hpp_pkg::CTL_CH1_INFULL_IRQ_ENABLE];
            ch2InfullIrq <= status[1][hpp_pkg::STS_INPUT_FULL]
                && portCtl_q[hpp_pkg::CTL_CH2_INFULL_IRQ_ENABLE];
            portEnabled <= portOn;
        end
    end

    // only channel one writes steer the gate; any other command disarms it
    always_ff @(posedge mclk) begin
        if (!nrst || (clkEn && standby)) begin
            gateArmed_q <= 1'b0;
            addressLineGateOut <= hpp_pkg::GATE_RESET_LEVEL;
        end else if (clkEn && hostWrDone[0]
            && portCtl_q[hpp_pkg::CTL_FAST_GATE_ENABLE]) begin
            if (pinsPrev_q.cmdDataAddrLine) begin
                gateArmed_q <= pinsPrev_q.hostDataBus == hpp_pkg::GATE_CMD;
            end else if (gateArmed_q) begin
                addressLineGateOut <= pinsPrev_q.hostDataBus[hpp_pkg::GATE_DATA_BIT];
                gateArmed_q <= 1'b0;
            end
        end
    end
endmodule // hpp_host_port
`default_nettype wire

// >>> rtl/hpp_pkg.sv
// package: register map, field positions and carrier types of the host parallel port
package hpp_pkg;
    // slave-side register addresses
    localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
    localparam logic [15:0] ADDR_SYSTEM_CONTROL = 16'hFFC4;
    localparam logic [15:0] ADDR_HOST_PORT_CONTROL = 16'hFFF0;
    localparam logic [15:0] ADDR_HOST_IN_DATA_CH1 = 16'hFFF4;
    localparam logic [15:0] ADDR_HOST_OUT_DATA_CH1 = 16'hFFF5;
    localparam logic [15:0] ADDR_HOST_STATUS_CH1 = 16'hFFF6;
    localparam logic [15:0] ADDR_HOST_IN_DATA_CH2 = 16'hFFFC;
    localparam logic [15:0] ADDR_HOST_OUT_DATA_CH2 = 16'hFFFD;
    localparam logic [15:0] ADDR_HOST_STATUS_CH2 = 16'hFFFE;
    // window that is gated by the port enable bit
    localparam logic [15:0] ADDR_GATED_LO = 16'hFFF0;
    localparam logic [15:0] ADDR_GATED_HI = 16'hFFFF;
    // reset values
    localparam logic [7:0] RST_SERIAL_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h09;
    localparam logic [7:0] RST_HOST_PORT_CONTROL = 8'hF8;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    // system control fields
    localparam int SYS_PORT_ENABLE_BIT = 1;
    localparam logic [7:0] SYS_READ_ONLY_MASK = 8'h08;
    // host port control fields
    localparam int CTL_FAST_GATE_ENABLE = 0;
    localparam int CTL_CH1_INFULL_IRQ_ENABLE = 1;
    localparam int CTL_CH2_INFULL_IRQ_ENABLE = 2;
    localparam logic [7:0] CTL_FIXED_ONES = 8'hF8;
    // status fields
    localparam int STS_OUTPUT_FULL = 0;
    localparam int STS_INPUT_FULL = 1;
    localparam int STS_CMD_DATA = 3;
    localparam logic [7:0] STS_USER_MASK = 8'hF4;
    // fast gate command and the data bit it copies
    localparam logic [7:0] GATE_CMD = 8'hD1;
    localparam int GATE_DATA_BIT = 1;
    localparam logic GATE_RESET_LEVEL = 1'b1;

    // host pin group, sampled into the clock domain
    typedef struct packed {
        logic chan1SelectN;
        logic chan2SelectN;
        logic cmdDataAddrLine;
        logic hostReadStrobeN;
        logic hostWriteStrobeN;
        logic [7:0] hostDataBus;
    } hpp_host_pins_t;

    // slave cpu bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } hpp_cpu_req_t;
endpackage

// >>> verification/hpp_host_model.sv
// partner model: external host processor driving the port pins
`timescale 1ns/1ns
`default_nettype none
module hpp_host_model (
    input wire logic mclk,
    input wire logic [7:0] busOut,
    input wire logic busOeN,
    output var hpp_pkg::hpp_host_pins_t pins
);
    logic sel1N = 1'b1;
    logic sel2N = 1'b1;
    logic lineQ = 1'b0;
    logic rdN = 1'b1;
    logic wrN = 1'b1;
    logic drv = 1'b0;
    logic [7:0] dat = 8'h00;
    logic [7:0] lastBus_q = 8'hA5;
    logic [7:0] busLevel;

    // ****
    // bus resolution
    // ****
    // no pull on the bus: a released line toggles so stale data never passes
    assign busLevel = !busOeN ? busOut : (drv ? dat : ~lastBus_q);
    assign pins = {sel1N, sel2N, lineQ, rdN, wrN, busLevel};
    // last seen level, feeds the floating pattern
    always @(posedge mclk) lastBus_q <= busLevel;

    // one host cycle; sel bit0 picks channel 1, bit1 channel 2
    task automatic access(input logic [1:0] sel, input logic wr, input logic line,
                          input logic [7:0] wdata, input int len, output logic [7:0] rdata);
        @(posedge mclk);
        sel1N <= !sel[0];
        sel2N <= !sel[1];
        lineQ <= line;
        drv <= wr;
        dat <= wdata;
        @(posedge mclk);
        if (wr) wrN <= 1'b0;
        else rdN <= 1'b0;
        repeat (len) @(posedge mclk);
        rdata = busLevel;
        rdN <= 1'b1;
        wrN <= 1'b1;
        @(posedge mclk);
        sel1N <= 1'b1;
        sel2N <= 1'b1;
        drv <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule // hpp_host_model
`default_nettype wire

// >>> verification/hpp_host_port_properties.sv
// checker: port-level properties of the host parallel port
`timescale 1ns/1ns
`default_nettype none
module hpp_host_port_properties (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic standby,
    input wire logic chan1SelectN,
    input wire logic chan2SelectN,
    input wire logic hostReadStrobeN,
    input wire logic hostDataBusOeN,
    input wire logic cpuRd,
    input wire logic cpuWr,
    input wire logic [15:0] cpuAddr,
    input wire logic [7:0] cpuWdata,
    input wire logic [7:0] cpuRdata,
    input wire logic cpuAck,
    input wire logic ch1InfullIrq,
    input wire logic ch2InfullIrq,
    input wire logic addressLineGateOut,
    input wire logic portEnabled
);
    // ****
    // properties, one clock domain
    // ****
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_ack;
        clkEn |=> cpuAck == $past(cpuRd || cpuWr);
    endproperty
    a_ack: assert property (p_ack) else $error("ack does not follow request");
    // a write one cycle back may have just set the enable bit, so it is excluded
    property p_gated;
        cpuRd && clkEn && cpuAddr >= hpp_pkg::ADDR_GATED_LO && !portEnabled && !$past(cpuWr)
            |=> cpuRdata == 8'h00;
    endproperty
    a_gated: assert property (p_gated) else $error("gated read not zero");
    property p_drive_en;
        !hostDataBusOeN |-> portEnabled;
    endproperty
    a_drive_en: assert property (p_drive_en) else $error("bus driven while disabled");
    property p_both_sel;
        (!chan1SelectN && !chan2SelectN) [*4] |-> hostDataBusOeN;
    endproperty
    a_both_sel: assert property (p_both_sel) else $error("bus driven with both selects");
    property p_rd_idle;
        hostReadStrobeN [*4] |-> hostDataBusOeN;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("bus driven without read");
    property p_irq1_off;
        cpuWr && clkEn && cpuAddr == hpp_pkg::ADDR_HOST_PORT_CONTROL && !cpuWdata[1]
            && portEnabled && !$past(cpuWr) |-> ##2 !ch1InfullIrq;
    endproperty
    a_irq1_off: assert property (p_irq1_off) else $error("ch1 irq not masked");
    property p_irq2_off;
        cpuWr && clkEn && cpuAddr == hpp_pkg::ADDR_HOST_PORT_CONTROL && !cpuWdata[2]
            && portEnabled && !$past(cpuWr) |-> ##2 !ch2InfullIrq;
    endproperty
    a_irq2_off: assert property (p_irq2_off) else $error("ch2 irq not masked");
    property p_enable;
        cpuWr && clkEn && cpuAddr == hpp_pkg::ADDR_SYSTEM_CONTROL
            |-> ##2 portEnabled == $past(cpuWdata[hpp_pkg::SYS_PORT_ENABLE_BIT], 2);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit not followed");
    property p_gate_reset;
        $rose(nrst) |-> addressLineGateOut;
    endproperty
    a_gate_reset: assert property (p_gate_reset) else $error("gate low after reset");
    // irq is a registered and of flag and enable, so allow two standby cycles
    property p_standby;
        (standby && clkEn) [*2] |=> addressLineGateOut && !ch1InfullIrq && !ch2InfullIrq;
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not clear");
endmodule // hpp_host_port_properties

bind hpp_host_port hpp_host_port_properties hpp_host_port_properties_inst (
    .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .standby(standby),
    .chan1SelectN(chan1SelectN), .chan2SelectN(chan2SelectN),
    .hostReadStrobeN(hostReadStrobeN), .hostDataBusOeN(hostDataBusOeN),
    .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
    .cpuRdata(cpuRdata), .cpuAck(cpuAck), .ch1InfullIrq(ch1InfullIrq),
    .ch2InfullIrq(ch2InfullIrq), .addressLineGateOut(addressLineGateOut),
    .portEnabled(portEnabled)
);
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: slave registers, host channels, fast gate and standby
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic standby = 1'b0;
    logic clkEn = 1'b1;
    logic cpuRd = 1'b0;
    logic cpuWr = 1'b0;
    logic [15:0] cpuAddr = 16'h0000;
    logic [7:0] cpuWdata = 8'h00;
    logic [7:0] cpuRdata;
    logic [7:0] busOut;
    logic cpuAck, ch1Irq, ch2Irq, gateOut, portEnabled, busOeN;
    hpp_pkg::hpp_host_pins_t pins;
    logic [7:0] expQ[$];
    logic chkQ[$];
    int errors = 0;
    int totalChecks = 0;
    logic [31:0] rnd = 32'hD608;
    logic [7:0] hv;
    logic [7:0] d;
    logic [15:0] base;
    logic [1:0] sel;

    always #2 mclk = ~mclk;

    hpp_host_port hpp_host_port_inst (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
        .standby(standby), .chan1SelectN(pins.chan1SelectN),
        .chan2SelectN(pins.chan2SelectN), .cmdDataAddrLine(pins.cmdDataAddrLine),
        .hostReadStrobeN(pins.hostReadStrobeN), .hostWriteStrobeN(pins.hostWriteStrobeN),
        .hostDataBusIn(pins.hostDataBus), .hostDataBusOut(busOut), .hostDataBusOeN(busOeN),
        .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
        .cpuRdata(cpuRdata), .cpuAck(cpuAck), .ch1InfullIrq(ch1Irq), .ch2InfullIrq(ch2Irq),
        .addressLineGateOut(gateOut), .portEnabled(portEnabled));
    hpp_host_model hpp_host_model_inst (.mclk(mclk), .busOut(busOut), .busOeN(busOeN),
        .pins(pins));

    // ****
    // helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // slave access; for a read v is the expected data, noted for the monitor
    task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        cpuRd <= !wr;
        cpuWr <= wr;
        cpuAddr <= a;
        cpuWdata <= v;
        chkQ.push_back(!wr);
        expQ.push_back(v);
        @(posedge mclk);
        cpuRd <= 1'b0;
        cpuWr <= 1'b0;
    endtask

    // host access with a random strobe length, long enough for the read path
    task automatic host(input logic [1:0] s, input logic wr, input logic line,
                        input logic [7:0] v);
        rnd = xs(rnd);
        hpp_host_model_inst.access(s, wr, line, v, 6 + int'(rnd[1:0]), hv);
    endtask

    task automatic end_sim();
        if (errors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // monitor: every ack retires the oldest note, reads are compared
    always @(posedge mclk) begin
        if (cpuAck === 1'b1 && chkQ.size() > 0) begin
            if (chkQ.pop_front()) check("cpuRdata", expQ.pop_front(), cpuRdata);
            else void'(expQ.pop_front());
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("[ERR] run timeout expected end seen hang");
        end_sim();
    end

    // ****
    // main sequence
    // ****
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        cpu(0, hpp_pkg::ADDR_SYSTEM_CONTROL, 8'h09);
        cpu(0, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'h00);
        host(2'b01, 1, 0, 8'h5A);
        cpu(1, hpp_pkg::ADDR_SYSTEM_CONTROL, 8'h02);
        cpu(0, hpp_pkg::ADDR_SYSTEM_CONTROL, 8'h0A);
        cpu(0, hpp_pkg::ADDR_HOST_STATUS_CH1, 8'h00);
        cpu(0, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'hF8);
        cpu(1, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'h07);
        cpu(0, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'hFF);
        cpu(0, 16'h1234, 8'h00);
        // channel 1 takes a data byte, channel 2 a command byte
        for (int ch = 0; ch < 2; ch++) begin
            base = ch ? hpp_pkg::ADDR_HOST_IN_DATA_CH2 : hpp_pkg::ADDR_HOST_IN_DATA_CH1;
            sel = ch ? 2'b10 : 2'b01;
            rnd = xs(rnd);
            d = rnd[7:0];
            cpu(0, base + 16'h0002, 8'h00);
            host(sel, 1, ch[0], d);
            check("infullIrq", 8'h01, {7'h00, ch ? ch2Irq : ch1Irq});
            cpu(0, base + 16'h0002, {4'h0, ch[0], 3'b010});
            cpu(0, base, d);
            cpu(0, base + 16'h0002, {4'h0, ch[0], 3'b000});
            cpu(1, base + 16'h0002, 8'hFF);
            cpu(1, base + 16'h0001, ~d);
            cpu(0, base + 16'h0002, {4'hF, ch[0], 3'b101});
            host(sel, 0, 1, 8'h00);
            check("hostStatus", {4'hF, ch[0], 3'b101}, hv);
            host(sel, 0, 0, 8'h00);
            check("hostOutData", ~d, hv);
            cpu(0, base + 16'h0002, {4'hF, ch[0], 3'b100});
        end
        host(2'b11, 0, 0, 8'h00);
        // gate follows bit 1 of the byte after the command, other bits random
        for (int b = 0; b < 2; b++) begin
            rnd = xs(rnd);
            host(2'b01, 1, 1, hpp_pkg::GATE_CMD);
            host(2'b01, 1, 0, (rnd[7:0] & 8'hFD) | {6'h00, b[0], 1'b0});
            check("gate", {7'h00, b[0]}, {7'h00, gateOut});
        end
        host(2'b01, 1, 1, hpp_pkg::GATE_CMD);
        host(2'b01, 1, 1, 8'hFF);
        host(2'b01, 1, 0, 8'h00);
        check("gateDisarm", 8'h01, {7'h00, gateOut});
        // fill channel 2 so that masking its interrupt is really seen
        host(2'b10, 1, 0, 8'h3C);
        cpu(1, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'h00);
        repeat (3) @(posedge mclk);
        check("maskedIrq", 8'h00, {6'h00, ch2Irq, ch1Irq});
        // clock enable low freezes everything, so standby must not clear yet
        clkEn <= 1'b0;
        standby <= 1'b1;
        repeat (3) @(posedge mclk);
        clkEn <= 1'b1;
        standby <= 1'b0;
        cpu(0, hpp_pkg::ADDR_HOST_STATUS_CH1, 8'hF6);
        standby <= 1'b1;
        repeat (3) @(posedge mclk);
        standby <= 1'b0;
        cpu(0, hpp_pkg::ADDR_HOST_STATUS_CH1, 8'h00);
        cpu(0, hpp_pkg::ADDR_HOST_PORT_CONTROL, 8'hF8);
        cpu(0, hpp_pkg::ADDR_SYSTEM_CONTROL, 8'h0A);
        for (int i = 0; i < 10 && chkQ.size() > 0; i++) @(posedge mclk);
        if (chkQ.size() > 0) begin
            errors++;
            $display("[ERR] pending reads expected 0 seen %0d", chkQ.size());
        end
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
